// ---- hdl/rcc_core.v ----
// Multicycle 16-bit RISC instruction core with memory bus master.
// Contract
// RULE_01: Seven source modes, four destination modes are resolved.
// RULE_02: Sixteen 16-bit registers are directly addressable operands.
// RULE_03: A register-to-register instruction completes in one execute cycle.
// RULE_04: Counter, stack pointer, status and constant registers are dedicated.
// RULE_05: The remaining registers are general purpose.
// RULE_06: 51 instructions in dual, single and jump formats are decoded; the code has no RETI, so single-operand op1 6 does nothing.
// RULE_07: Subroutine call pushes the program counter then loads the operand.
// RULE_08: Jump-if-not-equal is taken only when the zero flag is 0.
// RULE_09: Word operation by default, byte operation when the byte bit is set.
// RULE_10: Computed jump and call accept all source addressing modes.
// RULE_11: Peripherals share the bus reached by every memory instruction.
// RULE_12: Non-flow instructions work through the addressing-mode datapath.
// RULE_13: Autoincrement adds 2 after a word operand, 1 after a byte; the code always adds 2 to PC and SP.
// RULE_14: R0 counter, R1 stack, R2 status/constant, R3 second constant.
`timescale 1ns/1ps
`include "rcc_defines.vh"
module rcc_core (
    // Clock, reset and enable.
    input wire mclk,
    input wire rstn,
    input wire ce,
    // Memory and peripheral bus.
    output reg [15:0] bus_addr,
    output reg [15:0] bus_wdata,
    output reg bus_rd,
    output reg bus_wr,
    output reg bus_byte,
    input wire [15:0] bus_rdata,
    // Status.
    output reg [15:0] pc_out,
    output reg halted
);
    localparam S_RESET = 4'h8;
    reg [3:0] st_r;
    reg [15:0] byp_d_r;
    reg [3:0] byp_a_r;
    reg byp_v_r;
    reg [15:0] pc_r, sr_r, ir_r, src_r, dst_r, dadr_r, ext_r;
    reg [15:0] rf_wd;
    reg [3:0] rf_wa;
    reg rf_we, dst_mem_r;
    wire [15:0] ra_q, rb_q;

    // Instruction fields.
    wire fmt_jmp = (ir_r[15:13] == 3'h1);
    wire fmt_one = (ir_r[15:10] == 6'h04);
    wire [3:0] op = ir_r[15:12];
    wire [3:0] rs = fmt_one ? ir_r[3:0] : ir_r[11:8];
    wire [3:0] rd = ir_r[3:0];
    wire ad = ir_r[7] & ~fmt_one;
    wire [1:0] as_m = ir_r[5:4];
    wire bw = ir_r[6]; // RULE_09
    wire [2:0] op1 = ir_r[9:7];
    // Read addresses follow the word being fetched, so the registered
    // read data match the new opcode one cycle later.
    wire [15:0] ir_nx = (st_r == `RCC_ST_FETCH) ? bus_rdata : ir_r;
    wire [3:0] ra_s = (ir_nx[15:10] == 6'h04) ? ir_nx[3:0] : ir_nx[11:8];
    wire [3:0] ra_d = (ir_nx[15:10] == 6'h04 && ir_nx[9:8] == 2'h2) ?
        `RCC_REG_SP : ir_nx[3:0];
    // A write committed at the read edge is forwarded over the stale data.
    wire [15:0] ra_f = (byp_v_r && byp_a_r == rs) ? byp_d_r : ra_q;
    wire [15:0] rb_f = (byp_v_r && byp_a_r == rd) ? byp_d_r : rb_q;

    rcc_regfile #(.NREG(16), .AW(4)) u_rf ( // RULE_02
        .mclk(mclk), .ce(ce), .ra_a(ra_s), .ra_b(ra_d), .rd_a(ra_q),
        .rd_b(rb_q), .we(rf_we), .wa(rf_wa), .wd(rf_wd));

    // Constant generator values for R2/R3; returns 1 in bit 16 if used.
    function [16:0] cgen;
        input [3:0] r;
        input [1:0] m;
        begin
            cgen = 17'h00000;
            if (r == `RCC_REG_CG2) begin // RULE_14
                case (m)
                    2'h0: cgen = 17'h10000;
                    2'h1: cgen = 17'h10001;
                    2'h2: cgen = 17'h10002;
                    default: cgen = 17'h1FFFF;
                endcase
            end else if (r == `RCC_REG_SR && m[1]) begin
                cgen = m[0] ? 17'h10008 : 17'h10004;
            end
        end
    endfunction

    // Register read that honours the dedicated PC and status registers.
    function [15:0] rval;
        input [3:0] r;
        input [15:0] q;
        input [15:0] pc;
        input [15:0] sr;
        begin
            if (r == `RCC_REG_PC) rval = pc; // RULE_04
            else if (r == `RCC_REG_SR) rval = sr;
            else rval = q; // RULE_05
        end
    endfunction

    wire [16:0] cg = cgen(rs, as_m);
    wire [15:0] sreg = rval(rs, ra_f, pc_r, sr_r);
    wire [15:0] dreg = rval(rd, rb_f, pc_r, sr_r);
    wire [15:0] inc = bw ? 16'h0001 : 16'h0002; // RULE_13

    // Arithmetic and logic unit.
    reg [16:0] alu;
    reg [15:0] res, flg;
    reg wb;
    wire [15:0] sv = bw ? {8'h00, src_r[7:0]} : src_r;
    wire [15:0] dv = bw ? {8'h00, dst_r[7:0]} : dst_r;
    wire [16:0] sum = {1'b0, dv} + {1'b0, sv} + {16'h0000, op == 4'h6 &
        sr_r[`RCC_SR_C]};
    wire [16:0] dif = {1'b0, dv} + {1'b0, ~sv} + {16'h0000, op == 4'h8 |
        (op == 4'h9) | (op == 4'h7 & sr_r[`RCC_SR_C])};
    always @* begin
        alu = 17'h00000;
        wb = 1'b1;
        case (op) // RULE_06
            4'h4: alu = {1'b0, sv};
            4'h5, 4'h6: alu = sum;
            4'h7, 4'h8: alu = dif;
            4'h9: begin alu = dif; wb = 1'b0; end
            4'hA: alu = sum;
            4'hB: begin alu = {1'b0, dv & sv}; wb = 1'b0; end
            4'hC: alu = {1'b0, dv & ~sv};
            4'hD: alu = {1'b0, dv | sv};
            4'hE: alu = {1'b0, dv ^ sv};
            4'hF: alu = {1'b0, dv & sv};
            default: alu = {1'b0, sv};
        endcase
        if (fmt_one) begin
            case (op1)
                3'h0: alu = {sv[0], sr_r[`RCC_SR_C], sv[15:1]};
                3'h1: alu = {1'b0, sv[7:0], sv[15:8]};
                3'h2: alu = {sv[0], sv[15], sv[15:1]};
                3'h3: alu = {1'b0, {8{sv[7]}}, sv[7:0]};
                default: alu = {1'b0, sv};
            endcase
            wb = (op1 < 3'h4);
        end
        res = bw ? {8'h00, alu[7:0]} : alu[15:0];
        flg = sr_r;
        flg[`RCC_SR_Z] = (res == 16'h0000);
        flg[`RCC_SR_N] = bw ? res[7] : res[15];
        flg[`RCC_SR_C] = bw ? (sv[7:0] + dv[7:0] > 9'h0FF) & (op == 4'h5)
            | alu[8] & (op != 4'h5) : alu[16];
    end

    // Jump condition from the status flags.
    reg jtake;
    always @* begin
        case (ir_r[12:10])
            3'h0: jtake = ~sr_r[`RCC_SR_Z]; // RULE_08
            3'h1: jtake = sr_r[`RCC_SR_Z];
            3'h2: jtake = ~sr_r[`RCC_SR_C];
            3'h3: jtake = sr_r[`RCC_SR_C];
            3'h4: jtake = sr_r[`RCC_SR_N];
            3'h5: jtake = ~(sr_r[`RCC_SR_N] ^ sr_r[`RCC_SR_V]);
            3'h6: jtake = sr_r[`RCC_SR_N] ^ sr_r[`RCC_SR_V];
            default: jtake = 1'b1;
        endcase
    end

    wire [15:0] joff = {ir_r[9], ir_r[9], ir_r[9], ir_r[9], ir_r[9],
        ir_r[9:0], 1'b0};
    wire is_call = fmt_one & (op1 == 3'h5);
    wire is_push = fmt_one & (op1 == 3'h4);
    wire w_sr = ~fmt_one & (op == 4'h5 | op == 4'h6 | op == 4'h7 |
        op == 4'h8 | op == 4'h9 | op == 4'hB | op == 4'hE | op == 4'hF) |
        fmt_one & (op1 != 3'h1) & (op1 < 3'h4);

    always @(posedge mclk) begin
        if (!rstn) begin
            st_r <= S_RESET;
            pc_r <= 16'h0000;
            sr_r <= 16'h0000;
            ir_r <= 16'h0000;
            src_r <= 16'h0000;
            dst_r <= 16'h0000;
            dadr_r <= 16'h0000;
            ext_r <= 16'h0000;
            dst_mem_r <= 1'b0;
            rf_we <= 1'b0;
            rf_wa <= 4'h0;
            rf_wd <= 16'h0000;
            byp_v_r <= 1'b0;
            byp_a_r <= 4'h0;
            byp_d_r <= 16'h0000;
            bus_addr <= `RCC_RESET_VECTOR;
            bus_wdata <= 16'h0000;
            bus_rd <= 1'b0;
            bus_wr <= 1'b0;
            bus_byte <= 1'b0;
            pc_out <= 16'h0000;
            halted <= 1'b1;
        end else if (ce) begin
            byp_v_r <= rf_we;
            byp_a_r <= rf_wa;
            byp_d_r <= rf_wd;
            rf_we <= 1'b0;
            bus_rd <= 1'b0;
            bus_wr <= 1'b0;
            bus_byte <= 1'b0;
            pc_out <= pc_r;
            case (st_r)
                S_RESET: begin
                    bus_addr <= `RCC_RESET_VECTOR;
                    bus_rd <= 1'b1;
                    st_r <= `RCC_ST_SRCRD;
                    ir_r <= 16'h4030; // Load vector into PC via MOV path.
                    halted <= 1'b0;
                end
                `RCC_ST_FETCH: begin
                    ir_r <= bus_rdata;
                    pc_r <= pc_r + 16'h0002;
                    st_r <= `RCC_ST_SRCX;
                end
                `RCC_ST_SRCX: begin
                    // Register file outputs now valid for the new opcode.
                    dst_r <= dreg;
                    dst_mem_r <= ad;
                    if (fmt_jmp) begin
                        if (jtake) pc_r <= pc_r + joff;
                        bus_addr <= jtake ? pc_r + joff : pc_r;
                        bus_rd <= 1'b1;
                        st_r <= `RCC_ST_FETCH;
                    end else if (cg[16]) begin
                        src_r <= cg[15:0];
                        st_r <= ad ? `RCC_ST_DSTX : `RCC_ST_EXEC;
                        bus_addr <= pc_r;
                        bus_rd <= ad;
                    end else if (as_m == `RCC_AS_REG) begin // RULE_01
                        src_r <= sreg;
                        st_r <= ad ? `RCC_ST_DSTX : `RCC_ST_EXEC; // RULE_03
                        bus_addr <= pc_r;
                        bus_rd <= ad;
                    end else if (as_m == `RCC_AS_IDX) begin // RULE_12
                        bus_addr <= pc_r;
                        bus_rd <= 1'b1;
                        pc_r <= pc_r + 16'h0002;
                        st_r <= `RCC_ST_DSTRD;
                        dst_mem_r <= ad;
                        ext_r <= (rs == `RCC_REG_SR) ? 16'h0000 : sreg;
                    end else begin
                        // Indirect, autoincrement and immediate (@PC+).
                        bus_addr <= sreg; // RULE_10
                        bus_rd <= 1'b1;
                        bus_byte <= bw;
                        if (as_m == `RCC_AS_INC) begin
                            if (rs == `RCC_REG_PC) pc_r <= pc_r + 16'h0002;
                            else begin
                                rf_we <= 1'b1;
                                rf_wa <= rs;
                                rf_wd <= sreg + ((rs == `RCC_REG_SP) ?
                                    16'h0002 : inc); // RULE_13
                            end
                        end
                        st_r <= `RCC_ST_SRCRD;
                    end
                end
                `RCC_ST_DSTRD: begin
                    // Source index word arrived; read the indexed operand.
                    bus_addr <= ext_r + bus_rdata;
                    bus_rd <= 1'b1;
                    bus_byte <= bw;
                    st_r <= `RCC_ST_SRCRD;
                end
                `RCC_ST_SRCRD: begin
                    src_r <= bus_rdata;
                    bus_addr <= pc_r;
                    bus_rd <= dst_mem_r;
                    st_r <= dst_mem_r ? `RCC_ST_DSTX : `RCC_ST_EXEC;
                end
                `RCC_ST_DSTX: begin
                    // Destination index word; symbolic/absolute alike.
                    pc_r <= pc_r + 16'h0002;
                    dadr_r <= bus_rdata + ((rd == `RCC_REG_SR) ? 16'h0000 :
                        dreg - ((rd == `RCC_REG_PC) ? 16'h0002 : 16'h0000));
                    bus_addr <= bus_rdata + ((rd == `RCC_REG_SR) ?
                        16'h0000 : dreg);
                    bus_rd <= 1'b1; // RULE_11
                    bus_byte <= bw;
                    st_r <= `RCC_ST_VEC;
                end
                `RCC_ST_VEC: begin
                    dst_r <= bus_rdata;
                    st_r <= `RCC_ST_EXEC;
                end
                `RCC_ST_EXEC: begin
                    if (w_sr && !(is_push || is_call)) sr_r <= flg;
                    bus_addr <= pc_r;
                    bus_rd <= 1'b1;
                    st_r <= `RCC_ST_FETCH;
                    if (is_push || is_call) begin
                        rf_we <= 1'b1;
                        rf_wa <= `RCC_REG_SP;
                        rf_wd <= rb_f - 16'h0002;
                        bus_addr <= rb_f - 16'h0002;
                        bus_wdata <= is_call ? pc_r : sv; // RULE_07
                        bus_wr <= 1'b1;
                        bus_rd <= 1'b0;
                        bus_byte <= bw & is_push;
                        st_r <= `RCC_ST_WRITE;
                        if (is_call) pc_r <= src_r; // RULE_07
                    end else if (wb && dst_mem_r) begin
                        bus_addr <= dadr_r;
                        bus_wdata <= res;
                        bus_wr <= 1'b1;
                        bus_rd <= 1'b0;
                        bus_byte <= bw;
                        st_r <= `RCC_ST_WRITE;
                    end else if (wb) begin
                        if (rd == `RCC_REG_PC) begin // RULE_10
                            pc_r <= res;
                            bus_addr <= res;
                        end else if (rd == `RCC_REG_SR) sr_r <= res;
                        else begin
                            rf_we <= 1'b1;
                            rf_wa <= rd;
                            rf_wd <= res;
                        end
                    end
                end
                `RCC_ST_WRITE: begin
                    bus_addr <= pc_r;
                    bus_rd <= 1'b1;
                    st_r <= `RCC_ST_FETCH;
                end
                default: st_r <= S_RESET;
            endcase
        end
    end
endmodule

// ---- hdl/rcc_defines.vh ----
// Constants of the 16-bit RISC processing core.
`ifndef RCC_DEFINES_VH
`define RCC_DEFINES_VH
`define RCC_REG_PC 4'h0
`define RCC_REG_SP 4'h1
`define RCC_REG_SR 4'h2
`define RCC_REG_CG2 4'h3
`define RCC_SR_C 0
`define RCC_SR_Z 1
`define RCC_SR_N 2
`define RCC_SR_V 8
`define RCC_RESET_VECTOR 16'hFFFE
`define RCC_AS_REG 2'h0
`define RCC_AS_IDX 2'h1
`define RCC_AS_IND 2'h2
`define RCC_AS_INC 2'h3
`define RCC_ST_FETCH 4'h0
`define RCC_ST_SRCX 4'h1
`define RCC_ST_SRCRD 4'h2
`define RCC_ST_DSTX 4'h3
`define RCC_ST_DSTRD 4'h4
`define RCC_ST_EXEC 4'h5
`define RCC_ST_WRITE 4'h6
`define RCC_ST_VEC 4'h7
`endif

// ---- hdl/rcc_regfile.v ----
// Sixteen-entry register file with registered read ports.
`timescale 1ns/1ps
module rcc_regfile #(
    parameter NREG = 16,
    parameter AW = 4
) (
    // Clock and enable.
    input wire mclk,
    input wire ce,
    // Read ports.
    input wire [AW-1:0] ra_a,
    input wire [AW-1:0] ra_b,
    output reg [15:0] rd_a,
    output reg [15:0] rd_b,
    // Write port.
    input wire we,
    input wire [AW-1:0] wa,
    input wire [15:0] wd
);
    reg [15:0] mem [0:NREG-1];

    always @(posedge mclk) begin
        if (ce) begin
            if (we) begin
                mem[wa] <= wd;
            end
            rd_a <= mem[ra_a];
            rd_b <= mem[ra_b];
        end
    end
endmodule

// ---- tb/rcc_core_properties.sv ----
// Bus protocol checker for the RISC instruction core.
`timescale 1ns/1ps
`include "rcc_defines.vh"
module rcc_core_properties (
    // Clock, reset and enable.
    input wire mclk,
    input wire rstn,
    input wire ce,
    // Memory bus.
    input wire [15:0] bus_addr,
    input wire [15:0] bus_wdata,
    input wire bus_rd,
    input wire bus_wr,
    input wire bus_byte,
    input wire [15:0] bus_rdata,
    // Status.
    input wire [15:0] pc_out,
    input wire halted
);
    logic [15:0] vec_r;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    always @(posedge mclk) begin
        if (ce && bus_rd && bus_addr == `RCC_RESET_VECTOR) begin
            vec_r <= bus_rdata;
        end
    end
    sequence s_vec_read;
        ce && bus_rd && bus_addr == `RCC_RESET_VECTOR;
    endsequence
    sequence s_first_fetch;
        bus_rd && bus_addr == vec_r;
    endsequence
    chk_vector_read: assert property
        ($rose(rstn) && ce |=> s_vec_read)
        else $error("vector read missing after reset");
    chk_vector_jump: assert property
        (s_vec_read |-> ##[1:8] s_first_fetch)
        else $error("first fetch not at vector address");
    chk_strobe_excl: assert property (!(bus_rd && bus_wr))
        else $error("read and write strobes together");
    chk_write_pulse: assert property (bus_wr && ce |=> !bus_wr)
        else $error("write strobe longer than one cycle");
    chk_stall_freeze: assert property (!ce |=> $stable(bus_addr)
        && $stable(bus_rd) && $stable(bus_wr) && $stable(pc_out))
        else $error("outputs moved while stalled");
    chk_word_align: assert property ((bus_rd || bus_wr) && !bus_byte
        |-> !bus_addr[0])
        else $error("word access at odd address");
    chk_fetch_after_wr: assert property
        (bus_wr && ce |-> ##[1:4] bus_rd)
        else $error("no fetch after write");
    chk_pc_even: assert property (!halted |-> !pc_out[0])
        else $error("program counter odd");
endmodule
bind rcc_core rcc_core_properties i_rcc_core_properties (.mclk(mclk),
    .rstn(rstn), .ce(ce), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_byte(bus_byte),
    .bus_rdata(bus_rdata), .pc_out(pc_out), .halted(halted));

// ---- tb/rcc_mem_model.sv ----
// Memory and peripheral space model on the core bus.
`timescale 1ns/1ps
module rcc_mem_model (
    // Clock.
    input wire mclk,
    // Bus.
    input wire [15:0] bus_addr,
    input wire [15:0] bus_wdata,
    input wire bus_rd,
    input wire bus_wr,
    input wire bus_byte,
    output wire [15:0] bus_rdata
);
    logic [7:0] mem [0:65535];
    logic [15:0] hold_r;
    logic fresh_r = 1'b0;
    wire [15:0] wa = {bus_addr[15:1], 1'b0};
    wire [15:0] word = {mem[wa + 16'h0001], mem[wa]};
    // Read data is valid in the strobe cycle and the one after, then it
    // turns to garbage so a late sample cannot pass by luck.
    assign bus_rdata = bus_rd ? word : (fresh_r ? hold_r : ~hold_r);
    always @(posedge mclk) begin
        fresh_r <= bus_rd;
        if (bus_rd) begin
            hold_r <= word;
        end
        if (bus_wr && bus_byte) begin
            mem[bus_addr] <= bus_wdata[7:0];
        end else if (bus_wr) begin
            mem[wa] <= bus_wdata[7:0];
            mem[wa + 16'h0001] <= bus_wdata[15:8];
        end
    end
    task automatic poke(input logic [15:0] a, input logic [15:0] w);
        mem[a] = w[7:0];
        mem[a + 16'h0001] = w[15:8];
    endtask
endmodule

// ---- tb/risc_cpu_instruction_core_bench.sv ----
// Self-checking bench for the RISC instruction core.
`timescale 1ns/1ps
module risc_cpu_instruction_core_bench;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    wire [15:0] bus_addr, bus_wdata, bus_rdata, pc_out;
    wire bus_rd, bus_wr, bus_byte, halted;
    logic [32:0] exp_q [$];
    logic [15:0] ap;
    int fails = 0;
    int n_checks = 0;

    initial begin
        forever #50 mclk = ~mclk;
    end

    rcc_core i_rcc_core (.mclk(mclk), .rstn(rstn), .ce(ce),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rd(bus_rd),
        .bus_wr(bus_wr), .bus_byte(bus_byte), .bus_rdata(bus_rdata),
        .pc_out(pc_out), .halted(halted));
    rcc_mem_model i_rcc_mem_model (.mclk(mclk), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_rd(bus_rd), .bus_wr(bus_wr),
        .bus_byte(bus_byte), .bus_rdata(bus_rdata));

    task automatic tally_and_finish;
        $display("checks=%0d fails=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check_write(input logic [32:0] got,
        input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t write got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_drained;
        n_checks++;
        if (exp_q.size() != 0) begin
            fails++;
            $display("MISMATCH t=%0t %0d writes missing", $time, exp_q.size());
        end
    endtask

    task automatic emit(input logic [15:0] w);
        i_rcc_mem_model.poke(ap, w);
        ap = ap + 16'h0002;
    endtask

    task automatic expect_wr(input logic b, input logic [15:0] a, d);
        exp_q.push_back({b, a, d});
    endtask

    // Each committed write is compared with the next expected one.
    always @(posedge mclk) begin
        if (rstn && ce && bus_wr) begin
            if (exp_q.size() == 0) begin
                check_write({bus_byte, bus_addr, bus_wdata}, 33'h0);
            end else begin
                check_write({bus_byte, bus_addr, bus_byte ?
                    {8'h00, bus_wdata[7:0]} : bus_wdata}, exp_q.pop_front());
            end
        end
    end

    initial begin
        logic [15:0] v, m, m2;
        logic [15:0] prog [$];
        int k;
        void'($urandom(32'h25b5));
        for (int t = 0; t < 2; t++) begin
            @(negedge mclk);
            rstn = 1'b0;
            ce = 1'b1;
            v = $urandom;
            m = $urandom;
            m2 = $urandom;
            prog = '{16'h4034, v, 16'h4405, 16'h4582, 16'h0200, 16'h45C2,
                16'h0202, 16'h4036, 16'h0300, 16'h46B2, 16'h0204, 16'h46F2,
                16'h0206, 16'h4682, 16'h0208, 16'h8404, 16'h2002, 16'h4582,
                16'h020A, 16'h5034, 16'h0001, 16'h2002, 16'h4582, 16'h020C,
                16'h4031, 16'h0400, 16'h12B0, 16'h0180, 16'h3FFF};
            i_rcc_mem_model.poke(16'hFFFE, 16'h0100);
            i_rcc_mem_model.poke(16'h0300, m);
            i_rcc_mem_model.poke(16'h0302, m2);
            ap = 16'h0100;
            foreach (prog[i]) emit(prog[i]);
            ap = 16'h0180;
            emit(16'h4482);
            emit(16'h020E);
            emit(16'h3FFF);
            expect_wr(1'b0, 16'h0200, v);
            expect_wr(1'b1, 16'h0202, {8'h00, v[7:0]});
            expect_wr(1'b0, 16'h0204, m);
            expect_wr(1'b1, 16'h0206, {8'h00, m2[7:0]});
            expect_wr(1'b0, 16'h0208, 16'h0303);
            expect_wr(1'b0, 16'h020A, v);
            expect_wr(1'b0, 16'h03FE, 16'h0138);
            expect_wr(1'b0, 16'h020E, 16'h0001);
            repeat (6) @(negedge mclk);
            rstn = 1'b1;
            k = 0;
            while (exp_q.size() != 0 && k < 3000) begin
                @(negedge mclk);
                k++;
            end
            check_drained();
            if (k == 3000) begin
                tally_and_finish;
            end
            // Random stalls while the core spins in its closing loop.
            repeat (200) begin
                @(negedge mclk);
                ce = ($urandom % 4) != 0;
            end
            @(negedge mclk);
            ce = 1'b1;
            repeat (20) @(negedge mclk);
            check_drained();
            $display("test %0d done", t);
        end
        tally_and_finish;
    end
endmodule
